// ### verilog/ipcm_params.svh
// Constants of the interrupt pin configuration and mapping block.
// Assumes inclusion by bare name from the package and design modules.
`ifndef IPCM_PARAMS_SVH
`define IPCM_PARAMS_SVH

// ==========================================================
// Register offsets
`define IPCM_ADDR_PIN_A_ELEC  8'h53
`define IPCM_ADDR_PIN_B_ELEC  8'h54
`define IPCM_ADDR_LATCH       8'h55
`define IPCM_ADDR_PIN_A_FMAP  8'h56
`define IPCM_ADDR_PIN_B_FMAP  8'h57
`define IPCM_ADDR_HW_MAP      8'h58
`define IPCM_ADDR_INIT_CTRL   8'h59

// ==========================================================
// Reset values and writable-bit masks
`define IPCM_RESET_ZERO       8'h00
`define IPCM_RESET_INIT_CTRL  8'h90
`define IPCM_WMASK_ELEC       8'h1F
`define IPCM_WMASK_LATCH      8'h01
`define IPCM_WMASK_FMAP       8'hEE
`define IPCM_WMASK_HW_MAP     8'h77
`define IPCM_WMASK_ALL        8'hFF

// ==========================================================
// Field positions
`define IPCM_ELEC_LSB         0
`define IPCM_ELEC_MSB         4
`define IPCM_LATCH_BIT        0
`define IPCM_HW_PIN_A_LSB     0
`define IPCM_HW_PIN_A_MSB     2
`define IPCM_HW_PIN_B_LSB     4
`define IPCM_HW_PIN_B_MSB     6
`define IPCM_FMAP_STEP_BIT    1
`define IPCM_FMAP_ACT_BIT     2
`define IPCM_FMAP_TILT_BIT    3
`define IPCM_FMAP_WAKE_BIT    5
`define IPCM_FMAP_MOTION_BIT  6
`define IPCM_FMAP_ERROR_BIT   7

// ==========================================================
// Field encodings
`define IPCM_TRIG_EDGE        1'b1
`define IPCM_POL_HIGH         1'b1
`define IPCM_DRV_OPEN_DRAIN   1'b1
`define IPCM_LATCH_ON         1'b1
`define IPCM_BIT_ON           1'b1
`define IPCM_BIT_OFF          1'b0

`endif

// ### verilog/ipcm_pkg.sv
// Types shared by the interrupt pin configuration and mapping block.
// Assumes the constants header sits beside it.
`include "ipcm_params.svh"

package ipcm_pkg;

    // ==========================================================
    // Register port
    typedef struct packed {
        logic       wrEn;
        logic       rdEn;
        logic [7:0] addr;
        logic [7:0] wrData;
    } ipcm_reg_req_type;

    // ==========================================================
    // Electrical fields, bits 4..0 of a pin's control register
    typedef struct packed {
        logic inEn;
        logic outEn;
        logic driverType;
        logic polarity;
        logic trigMode;
    } ipcm_elec_type;

    // ==========================================================
    // Event sources
    typedef struct packed {
        logic errorEvt;
        logic anyNoMotionEvt;
        logic wakeupEvt;
        logic wristTiltEvt;
        logic activityEvt;
        logic stepEvt;
    } ipcm_feature_evt_type;

    typedef struct packed {
        logic sampleReadyEvt;
        logic watermarkEvt;
        logic bufferFullEvt;
    } ipcm_hw_evt_type;

    // ==========================================================
    // Pin driver state
    typedef struct packed {
        logic pinOut;
        logic pinOe;
        logic inEvent;
        logic inActivePrev;
    } ipcm_pin_state_type;

    // ==========================================================
    // Top-level state
    typedef struct packed {
        logic [7:0] pinAElec;
        logic [7:0] pinBElec;
        logic [7:0] latchMode;
        logic [7:0] pinAFeatureMap;
        logic [7:0] pinBFeatureMap;
        logic [7:0] hwEventMap;
        logic [7:0] initStartCtrl;
        logic [1:0] held;
        logic [7:0] rdData;
    } ipcm_state_type;

endpackage

// ### verilog/ipcm_pin_driver.sv
// One interrupt pin: output driver and input trigger detection.
// Assumes a synchronous pin input and an unregistered assert request, which it registers itself.
`timescale 1ns/10ps
`default_nettype none
`include "ipcm_params.svh"

module ipcm_pin_driver (
    input  wire logic                   clk_sys,
    input  wire logic                   reset_n,
    input  wire ipcm_pkg::ipcm_elec_type elec,
    input  wire logic                   assertReq,
    input  wire logic                   pinIn,
    output logic                        pinOut,
    output logic                        pinOe,
    output logic                        pinInEvent
);

    ipcm_pkg::ipcm_pin_state_type state_r;
    ipcm_pkg::ipcm_pin_state_type state_nxt;

    logic pinLevel;
    logic inActive;

    // ==========================================================
    // Next state
    always_comb begin
        state_nxt = state_r;
        // Electrical level of an asserted or idle pin
        pinLevel  = (elec.polarity == `IPCM_POL_HIGH) ? assertReq : ~assertReq;
        inActive  = (elec.polarity == `IPCM_POL_HIGH) ? pinIn : ~pinIn;
        if (elec.outEn == `IPCM_BIT_ON) begin
            if (elec.driverType == `IPCM_DRV_OPEN_DRAIN) begin
                // Open drain can only pull low; high comes from the pull-up
                state_nxt.pinOut = `IPCM_BIT_OFF;
                state_nxt.pinOe  = ~pinLevel;
            end else begin
                state_nxt.pinOut = pinLevel;
                state_nxt.pinOe  = `IPCM_BIT_ON;
            end
        end else begin
            state_nxt.pinOut = `IPCM_BIT_OFF;
            state_nxt.pinOe  = `IPCM_BIT_OFF;
        end
        state_nxt.inActivePrev = inActive;
        if (elec.inEn != `IPCM_BIT_ON) begin
            state_nxt.inEvent = `IPCM_BIT_OFF;
        end else if (elec.trigMode == `IPCM_TRIG_EDGE) begin
            state_nxt.inEvent = inActive & ~state_r.inActivePrev;
        end else begin
            state_nxt.inEvent = inActive;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign pinOut     = state_r.pinOut;
    assign pinOe      = state_r.pinOe;
    assign pinInEvent = state_r.inEvent;

endmodule
`default_nettype wire

// ### verilog/ipcm_interrupt_pin_config.sv
// Interrupt pin configuration and event routing, top level.
// Assumes a synchronous byte-wide register port driven by the host
// interface logic, event sources that are levels or one-cycle pulses
// on clk_sys, and a pulse when the host reads the interrupt status.
`timescale 1ns/10ps
`default_nettype none
`include "ipcm_params.svh"

module ipcm_interrupt_pin_config (
    input  wire logic                          clk_sys,
    input  wire logic                          reset_n,
    input  wire ipcm_pkg::ipcm_reg_req_type    regReq,
    output logic [7:0]                         regRdData,
    input  wire ipcm_pkg::ipcm_feature_evt_type featureEvt,
    input  wire ipcm_pkg::ipcm_hw_evt_type     hwEvt,
    input  wire logic                          intStatusRead,
    output logic [7:0]                         initStartCtrl,
    input  wire logic                          irqPinAIn,
    output logic                               irqPinAOut,
    output logic                               irqPinAOe,
    output logic                               irqPinAInEvent,
    input  wire logic                          irqPinBIn,
    output logic                               irqPinBOut,
    output logic                               irqPinBOe,
    output logic                               irqPinBInEvent
);

    ipcm_pkg::ipcm_state_type state_r;
    ipcm_pkg::ipcm_state_type state_nxt;

    logic [7:0] featureVec;
    logic [1:0] source;
    logic [1:0] assertReq;
    logic       latched;

    // ==========================================================
    // Feature events laid out on the map register bit positions
    always_comb begin
        featureVec                          = `IPCM_RESET_ZERO;
        featureVec[`IPCM_FMAP_STEP_BIT]     = featureEvt.stepEvt;
        featureVec[`IPCM_FMAP_ACT_BIT]      = featureEvt.activityEvt;
        featureVec[`IPCM_FMAP_TILT_BIT]     = featureEvt.wristTiltEvt;
        featureVec[`IPCM_FMAP_WAKE_BIT]     = featureEvt.wakeupEvt;
        featureVec[`IPCM_FMAP_MOTION_BIT]   = featureEvt.anyNoMotionEvt;
        featureVec[`IPCM_FMAP_ERROR_BIT]    = featureEvt.errorEvt;
    end

    // ==========================================================
    // Source routing per pin
    always_comb begin
        // Reserved map bits are held at zero, so the full-width AND is safe
        source[0] = |(state_r.pinAFeatureMap & featureVec)
                  | |(state_r.hwEventMap[`IPCM_HW_PIN_A_MSB:`IPCM_HW_PIN_A_LSB] & hwEvt);
        source[1] = |(state_r.pinBFeatureMap & featureVec)
                  | |(state_r.hwEventMap[`IPCM_HW_PIN_B_MSB:`IPCM_HW_PIN_B_LSB] & hwEvt);
        latched   = (state_r.latchMode[`IPCM_LATCH_BIT] == `IPCM_LATCH_ON);
        // A held pin stays asserted; a new event shows without waiting a cycle
        assertReq = latched ? (state_r.held | source) : source;
    end

    // ==========================================================
    // Register writes, latch hold and read data
    always_comb begin
        state_nxt = state_r;

        // Set wins over the status-read clear so no event is lost
        if (latched) begin
            state_nxt.held = (intStatusRead ? 2'h0 : state_r.held) | source;
        end else begin
            state_nxt.held = 2'h0;
        end

        if (regReq.wrEn) begin
            unique case (regReq.addr)
                `IPCM_ADDR_PIN_A_ELEC: begin
                    state_nxt.pinAElec = regReq.wrData & `IPCM_WMASK_ELEC;
                end
                `IPCM_ADDR_PIN_B_ELEC: begin
                    state_nxt.pinBElec = regReq.wrData & `IPCM_WMASK_ELEC;
                end
                `IPCM_ADDR_LATCH: begin
                    state_nxt.latchMode = regReq.wrData & `IPCM_WMASK_LATCH;
                end
                `IPCM_ADDR_PIN_A_FMAP: begin
                    state_nxt.pinAFeatureMap = regReq.wrData & `IPCM_WMASK_FMAP;
                end
                `IPCM_ADDR_PIN_B_FMAP: begin
                    state_nxt.pinBFeatureMap = regReq.wrData & `IPCM_WMASK_FMAP;
                end
                `IPCM_ADDR_HW_MAP: begin
                    state_nxt.hwEventMap = regReq.wrData & `IPCM_WMASK_HW_MAP;
                end
                `IPCM_ADDR_INIT_CTRL: begin
                    state_nxt.initStartCtrl = regReq.wrData & `IPCM_WMASK_ALL;
                end
                default: begin
                    // Writes outside the block are ignored
                end
            endcase
        end

        // Read data is registered; unmapped addresses read zero
        state_nxt.rdData = `IPCM_RESET_ZERO;
        if (regReq.rdEn) begin
            unique case (regReq.addr)
                `IPCM_ADDR_PIN_A_ELEC: begin
                    state_nxt.rdData = state_r.pinAElec;
                end
                `IPCM_ADDR_PIN_B_ELEC: begin
                    state_nxt.rdData = state_r.pinBElec;
                end
                `IPCM_ADDR_LATCH: begin
                    state_nxt.rdData = state_r.latchMode;
                end
                `IPCM_ADDR_PIN_A_FMAP: begin
                    state_nxt.rdData = state_r.pinAFeatureMap;
                end
                `IPCM_ADDR_PIN_B_FMAP: begin
                    state_nxt.rdData = state_r.pinBFeatureMap;
                end
                `IPCM_ADDR_HW_MAP: begin
                    state_nxt.rdData = state_r.hwEventMap;
                end
                `IPCM_ADDR_INIT_CTRL: begin
                    state_nxt.rdData = state_r.initStartCtrl;
                end
                default: begin
                    state_nxt.rdData = `IPCM_RESET_ZERO;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_r                <= '0;
            state_r.pinAElec       <= `IPCM_RESET_ZERO;
            state_r.pinBElec       <= `IPCM_RESET_ZERO;
            state_r.latchMode      <= `IPCM_RESET_ZERO;
            state_r.pinAFeatureMap <= `IPCM_RESET_ZERO;
            state_r.pinBFeatureMap <= `IPCM_RESET_ZERO;
            state_r.hwEventMap     <= `IPCM_RESET_ZERO;
            state_r.initStartCtrl  <= `IPCM_RESET_INIT_CTRL;
            state_r.rdData         <= `IPCM_RESET_ZERO;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign regRdData     = state_r.rdData;
    assign initStartCtrl = state_r.initStartCtrl;

    // ==========================================================
    // Pin drivers
    ipcm_pin_driver pinADriver (
        .clk_sys    (clk_sys),
        .reset_n    (reset_n),
        .elec       (ipcm_pkg::ipcm_elec_type'(state_r.pinAElec[`IPCM_ELEC_MSB:`IPCM_ELEC_LSB])),
        .assertReq  (assertReq[0]),
        .pinIn      (irqPinAIn),
        .pinOut     (irqPinAOut),
        .pinOe      (irqPinAOe),
        .pinInEvent (irqPinAInEvent)
    );

    ipcm_pin_driver pinBDriver (
        .clk_sys    (clk_sys),
        .reset_n    (reset_n),
        .elec       (ipcm_pkg::ipcm_elec_type'(state_r.pinBElec[`IPCM_ELEC_MSB:`IPCM_ELEC_LSB])),
        .assertReq  (assertReq[1]),
        .pinIn      (irqPinBIn),
        .pinOut     (irqPinBOut),
        .pinOe      (irqPinBOe),
        .pinInEvent (irqPinBInEvent)
    );

endmodule
`default_nettype wire

// ### testbench/ipcm_host_model.sv
// Host side of one interrupt line: resolves the level seen on the wire.
// Assumes a pull-up on the line and a host that may drive it itself.
`timescale 1ns/10ps
`default_nettype none

// ======
// Line resolution
module ipcm_host_model (
    input  wire logic pinOut,
    input  wire logic pinOe,
    input  wire logic hostDrive,
    input  wire logic hostLevel,
    output logic      wireLevel
);
    // A released line rises through the pull-up, never keeps a stale level
    assign wireLevel = pinOe ? pinOut : (hostDrive ? hostLevel : 1'h1);
endmodule

`default_nettype wire

// ### testbench/ipcm_interrupt_pin_config_properties.sv
// Concurrent checks on the ports of the pin configuration block.
// Assumes one clock domain; bound to the top module at the foot.
`timescale 1ns/10ps
`default_nettype none

// ======
// Checker
module ipcm_interrupt_pin_config_properties (
    input wire logic                       clk_sys,
    input wire logic                       reset_n,
    input wire ipcm_pkg::ipcm_reg_req_type regReq,
    input wire logic [7:0]                 regRdData,
    input wire logic                       irqPinBIn,
    input wire logic                       irqPinBOut,
    input wire logic                       irqPinBOe,
    input wire logic                       irqPinBInEvent
);
    // Pin B control bits as the design should hold them
    logic [4:0] shB_r;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            shB_r <= 5'h00;
        end else if (regReq.wrEn && regReq.addr == 8'h54) begin
            shB_r <= regReq.wrData[4:0];
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    chk_elec_rsvd: assert property (regReq.rdEn && regReq.addr == 8'h54 |=> regRdData[7:5] == 3'h0)
        else $error("pin B control reserved bits read nonzero");
    chk_latch_rsvd: assert property (regReq.rdEn && regReq.addr == 8'h55 |=> regRdData[7:1] == 7'h00)
        else $error("latch mode reserved bits read nonzero");
    chk_fmap_rsvd: assert property (regReq.rdEn && regReq.addr inside {8'h56, 8'h57}
        |=> !regRdData[0] && !regRdData[4]) else $error("feature map reserved bits read nonzero");
    chk_hwmap_rsvd: assert property (regReq.rdEn && regReq.addr == 8'h58 |=> !regRdData[3] && !regRdData[7])
        else $error("hardware map reserved bits read nonzero");
    chk_drive_off: assert property (!shB_r[3] |=> !irqPinBOe && !irqPinBOut)
        else $error("pin B driven while output disabled");
    chk_pp_drive: assert property (shB_r[3] && !shB_r[2] |=> irqPinBOe)
        else $error("push-pull pin B not driven");
    chk_od_low: assert property (shB_r[3] && shB_r[2] |=> !irqPinBOut)
        else $error("open-drain pin B drives high");
    chk_in_off: assert property (!shB_r[4] |=> !irqPinBInEvent)
        else $error("input event while input disabled");
    chk_edge_pulse: assert property (shB_r[4] && shB_r[0] && irqPinBInEvent |=> !irqPinBInEvent)
        else $error("edge input event longer than one cycle");
    chk_level_follow: assert property (shB_r[4] && !shB_r[0] && irqPinBIn == shB_r[1] |=> irqPinBInEvent)
        else $error("level input event missing");

    cov_edge: cover property (shB_r[0] && irqPinBInEvent);
    cov_od: cover property (shB_r[2] && irqPinBOe);
    cov_read: cover property (regReq.rdEn ##1 regRdData != 8'h00);
endmodule

bind ipcm_interrupt_pin_config ipcm_interrupt_pin_config_properties ipcm_interrupt_pin_config_properties_inst (
    .clk_sys(clk_sys), .reset_n(reset_n), .regReq(regReq), .regRdData(regRdData), .irqPinBIn(irqPinBIn),
    .irqPinBOut(irqPinBOut), .irqPinBOe(irqPinBOe), .irqPinBInEvent(irqPinBInEvent));

`default_nettype wire

// ### testbench/ipcm_interrupt_pin_config_test.sv
// Self-checking bench for the interrupt pin configuration block.
// Assumes the host model file and the package are compiled first.
`timescale 1ns/10ps
`default_nettype none

// ======
// Bench
module ipcm_interrupt_pin_config_test;
    logic                           clk_sys = 1'h0;
    logic                           reset_n = 1'h0;
    ipcm_pkg::ipcm_reg_req_type     regReq = '0;
    ipcm_pkg::ipcm_feature_evt_type featureEvt = '0;
    ipcm_pkg::ipcm_hw_evt_type      hwEvt = '0;
    logic                           intStatusRead = 1'h0;
    logic                           hostDriveB = 1'h0;
    logic                           hostLevelB = 1'h0;
    logic [7:0]                     regRdData, initStartCtrl;
    logic                           wireA, wireB, aOut, aOe, aEv, bOut, bOe, bEv;
    int                             n_errors = 0;
    int                             checks = 0;
    logic [7:0] regAddr [8] = '{8'h53, 8'h54, 8'h55, 8'h56, 8'h57, 8'h58, 8'h59, 8'h5A};
    logic [7:0] rstVal  [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h90, 8'h00};
    logic [7:0] maskVal [8] = '{8'h1F, 8'h1F, 8'h01, 8'hEE, 8'hEE, 8'h77, 8'hFF, 8'h00};
    int         mapPos  [6] = '{1, 2, 3, 5, 6, 7};
    logic [7:0] elecTab [4] = '{8'h08, 8'h0C, 8'h0E, 8'h02};
    logic [1:0] oeTab   [4] = '{2'h3, 2'h2, 2'h1, 2'h0};
    logic [1:0] lvTab   [4] = '{2'h1, 2'h1, 2'h2, 2'h3};
    logic [7:0] inTab   [4] = '{8'h13, 8'h11, 8'h10, 8'h03};
    logic [2:0] evTab   [4] = '{3'h2, 3'h2, 3'h3, 3'h0};

    always #25 clk_sys = ~clk_sys;

    ipcm_interrupt_pin_config ipcm_interrupt_pin_config_inst (
        .clk_sys(clk_sys), .reset_n(reset_n), .regReq(regReq), .regRdData(regRdData), .featureEvt(featureEvt),
        .hwEvt(hwEvt), .intStatusRead(intStatusRead), .initStartCtrl(initStartCtrl), .irqPinAIn(wireA),
        .irqPinAOut(aOut), .irqPinAOe(aOe), .irqPinAInEvent(aEv), .irqPinBIn(wireB), .irqPinBOut(bOut),
        .irqPinBOe(bOe), .irqPinBInEvent(bEv));
    ipcm_host_model ipcm_host_model_inst (
        .pinOut(aOut), .pinOe(aOe), .hostDrive(1'h0), .hostLevel(1'h0), .wireLevel(wireA));
    ipcm_host_model ipcm_host_model_inst_b (
        .pinOut(bOut), .pinOe(bOe), .hostDrive(hostDriveB), .hostLevel(hostLevelB), .wireLevel(wireB));

    // ======
    // Tasks
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    // Each access ends with an idle cycle so no strobe is set twice in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        regReq = '{wrEn: 1'h1, rdEn: 1'h0, addr: a, wrData: d};
        settle(1);
        regReq = '0;
        settle(1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        regReq = '{wrEn: 1'h0, rdEn: 1'h1, addr: a, wrData: 8'h00};
        settle(1);
        regReq = '0;
        check($sformatf("register %h", a), regRdData, exp);
        settle(1);
    endtask
    task automatic pins(input logic a, input logic b);
        check("pin wires", {6'h00, wireA, wireB}, {6'h00, a, b});
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ======
    // Tests
    initial begin
        settle(5);
        reset_n = 1'h1;
        check("init port", initStartCtrl, 8'h90);
        for (int i = 0; i < 8; i++) rd(regAddr[i], rstVal[i]);
        for (int i = 0; i < 8; i++) begin
            wr(regAddr[i], 8'hFF);
            rd(regAddr[i], maskVal[i]);
        end
        check("init port written", initStartCtrl, 8'hFF);
        for (int i = 0; i < 7; i++) wr(regAddr[i], 8'h00);
        $display("test registers done");
        wr(8'h53, 8'h0A);
        wr(8'h54, 8'h0A);
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 6; i++) begin
                wr(regAddr[3 + p], 8'h01 << mapPos[i]);
                featureEvt = 6'h01 << i;
                settle(3);
                pins(p == 0, p == 1);
                featureEvt = ~(6'h01 << i);
                settle(3);
                pins(1'h0, 1'h0);
                featureEvt = '0;
                wr(regAddr[3 + p], 8'h00);
            end
            for (int j = 0; j < 3; j++) begin
                wr(8'h58, 8'h01 << (j + 4 * p));
                hwEvt = 3'h1 << j;
                settle(3);
                pins(p == 0, p == 1);
                hwEvt = ~(3'h1 << j);
                settle(3);
                pins(1'h0, 1'h0);
                hwEvt = '0;
            end
            wr(8'h58, 8'h00);
        end
        $display("test routing done");
        wr(8'h56, 8'h02);
        for (int k = 0; k < 4; k++) begin
            wr(8'h53, elecTab[k]);
            for (int e = 0; e < 2; e++) begin
                featureEvt.stepEvt = e[0];
                settle(3);
                check("pin A enable", {7'h00, aOe}, {7'h00, oeTab[k][e]});
                check("pin A wire", {7'h00, wireA}, {7'h00, lvTab[k][e]});
            end
        end
        featureEvt = '0;
        $display("test electrical done");
        wr(8'h53, 8'h0A);
        wr(8'h55, 8'h01);
        featureEvt.stepEvt = 1'h1;
        settle(1);
        featureEvt.stepEvt = 1'h0;
        settle(4);
        pins(1'h1, 1'h0);
        // An event in the same cycle as the status read must keep the pin held
        featureEvt.stepEvt = 1'h1;
        intStatusRead = 1'h1;
        settle(1);
        featureEvt.stepEvt = 1'h0;
        intStatusRead = 1'h0;
        settle(3);
        pins(1'h1, 1'h0);
        intStatusRead = 1'h1;
        settle(1);
        intStatusRead = 1'h0;
        settle(3);
        pins(1'h0, 1'h0);
        wr(8'h55, 8'h00);
        $display("test latch done");
        hostDriveB = 1'h1;
        for (int k = 0; k < 4; k++) begin
            // Idle at the inactive level, then step to the active one
            hostLevelB = ~inTab[k][1];
            wr(8'h54, inTab[k]);
            settle(3);
            check("pin B event idle", {7'h00, bEv}, {7'h00, evTab[k][2]});
            hostLevelB = inTab[k][1];
            settle(1);
            check("pin B event first", {7'h00, bEv}, {7'h00, evTab[k][1]});
            settle(1);
            check("pin B event second", {7'h00, bEv}, {7'h00, evTab[k][0]});
        end
        wr(8'h53, 8'h12);
        settle(2);
        check("pin A event level", {7'h00, aEv}, 8'h01);
        wr(8'h53, 8'h02);
        settle(2);
        check("pin A event off", {7'h00, aEv}, 8'h00);
        $display("test input done");
        tally_and_finish();
    end

    initial begin
        #(20000 * 50);
        n_errors++;
        $display("watchdog expired");
        tally_and_finish();
    end
endmodule

`default_nettype wire
